// [dv/rspc_props.sv]
// Purpose: port checks of the reset source power control block
// Assumes: rc_mode held steady around speed writes
// Notes:   stall bound of 1000 cycles needs a small slow stall count
`timescale 1ns/10ps
module rspc_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        watchdog_config_enable,
  input wire logic        watchdog_run,
  input wire logic        rc_mode,
  input wire logic        rc_fast_select,
  input wire logic        core_stall
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read not held");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready not a pulse");
  a_rdata_high: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  a_wdt_forced: assert property (
    watchdog_config_enable |=> watchdog_run) else $error("run not forced");
  a_stall_rc: assert property (
    $rose(core_stall) |-> $past(rc_mode)) else $error("stall outside rc");
  a_stall_min: assert property (
    $rose(core_stall) |-> core_stall [*8]) else $error("stall too short");
  a_stall_max: assert property (
    $rose(core_stall) |-> ##[1:1000] !core_stall) else $error("stall hangs");
  a_sel_stable: assert property (
    core_stall && $past(core_stall) |-> $stable(rc_fast_select))
    else $error("select moved in stall");
endmodule
////////////////////////////////////////////////////////////////////////////
bind reset_source_power_control rspc_props rspc_props_inst (.*);

// [dv/tb_top.sv]
// Purpose: self-checking bench of the reset source power control block
// Assumes: small slow stall count so the run stays short
// Notes:   xorshift stimulus starts at 56
`timescale 1ns/10ps
module tb_top;
  localparam int P = 50;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, rc_mode = 0;
  logic watchdog_config_enable = 0, brownout_detect_enable = 1;
  logic por_event = 0, bor_event = 0;
  localparam logic [9:0] A_PRS = 10'h238, A_ST = 10'h240, A_MK = 10'h244;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, d, st = 56;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, watchdog_run, rc_fast_select, core_stall, irq;
  int fail_count = 0, samples_checked = 0, cur = 0, last = 0;
  reset_source_power_control #(.SLOW_STALL(P))
    reset_source_power_control_inst (.*);
  always #2.5 aclk = ~aclk;
  // length of the last stall, seen only at its end
  always @(posedge aclk) begin
    if (core_stall) cur <= cur + 1;
    else if (cur != 0) begin
      last <= cur;
      cur <= 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic wrap_up();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e, input string n);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 2000) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 2000; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    tmo(n);
  endtask
  task automatic rdr(input logic [9:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 2000; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    tmo(n);
  endtask
  task automatic spd(input logic [31:0] v, input int lo, hi);
    int n;
    last = 0;
    wr(A_PRS, v);
    for (n = 0; n < 2000 && last == 0; n++) @(posedge aclk);
    tmo(n);
    chk(last >= lo && last <= hi, 1, "stall length");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    por_event <= 1;
    @(posedge aclk);
    por_event <= 0;
    rdr(A_PRS);
    chk(rd & 32'h1e, 32'h08, "por flag");
    wr(A_PRS, 32'hff);
    rdr(A_PRS);
    chk(rd, 32'h1b, "reserved bits");
    repeat (4) begin
      d = xs() | 32'h8;
      wr(A_PRS, d);
      rdr(A_PRS);
      chk(rd, d & 32'h1b, "random value");
      chk(watchdog_run, d[4], "watchdog run");
    end
    wr(A_PRS, 32'h1b);
    watchdog_config_enable <= 1;
    wr(A_PRS, 32'h0b);
    rdr(A_PRS);
    chk(rd, 32'h1b, "forced enable");
    watchdog_config_enable <= 0;
    bor_event <= 1;
    @(posedge aclk);
    bor_event <= 0;
    rdr(A_PRS);
    chk(rd, 32'h1a, "brownout clear");
    chk(watchdog_run, 1, "soft enable kept");
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdr(A_PRS);
    chk(rd & 32'h3, 32'h2, "flags kept");
    por_event <= 1;
    wr(A_PRS, 32'h1b);
    por_event <= 0;
    rdr(A_PRS);
    chk(rd[1], 0, "clear priority");
    wr(A_ST, 32'h7);
    rdr(A_ST);
    chk(rd, 32'h0, "status clear");
    // slow setting first, outside rc mode, so entering rc mode is quiet
    wr(A_PRS, 32'h13);
    rc_mode <= 1;
    spd(32'h1b, 250, 650);
    chk(rc_fast_select, 1, "fast select");
    spd(32'h13, P, 3 * P);
    chk(rc_fast_select, 0, "slow select");
    chk(irq, 0, "irq masked");
    wr(A_MK, 32'h4);
    repeat (3) @(posedge aclk);
    chk(irq, 1, "irq raised");
    wr(A_ST, 32'h4);
    repeat (3) @(posedge aclk);
    chk(irq, 0, "irq cleared");
    rc_mode <= 0;
    last = 0;
    wr(A_PRS, 32'h1b);
    repeat (20) @(posedge aclk);
    chk(last, 0, "no stall outside rc");
    chk(rc_fast_select, 0, "select ignored");
    rdr(10'h100);
    chk({rs, rd}, {2'b10, 32'h0}, "unmapped read");
    wr(10'h100, 32'h1);
    chk(rs, 2'b10, "unmapped write");
    wrap_up();
  end
endmodule

// [verilog/pwr_ctl_map.svh]
// Purpose: offsets, fields, reset values and timing counts of the
//          reset source and power control block
// Assumes: 200 MHz aclk
// Notes:   see list below
// Operation
// (R01) unused bits 7-5 and bit 2 read zero, writes ignored
// (R02) watchdog config enable high forces soft enable to read one
// (R03) with config enable low, watchdog runs while soft enable is one
// (R04) in rc mode speed bit picks 4 MHz or 37 kHz, else ignored
// (R05) fast to slow switch stalls the core 100 to 300 us
// (R06) slow to fast switch stalls the core 1.25 to 3.25 us
// (R07) power-on reset clears the power-on flag; software sets it later
// (R08) brown-out reset clears brown-out flag; one means none since set
// (R09) brown-out flag undefined after power-on; software sets and checks
// (R10) brown-out flag meaningless while brown-out detect is disabled
// (R11) pin and watchdog resets leave both flags unchanged
// (R12) hardware clear beats a same-cycle software set
`ifndef PWR_CTL_MAP_SVH
`define PWR_CTL_MAP_SVH

// register indices; byte address is four times the index
`define PRS_INDEX        8'h8e
`define IRQ_STATUS_IDX   8'h90
`define IRQ_MASK_IDX     8'h91

`define BIT_SOFT_WDT     4
`define BIT_SPEED        3
`define BIT_POR          1
`define BIT_BOR          0
`define PRS_WMASK        8'h1b

`define SPEED_RESET      1'b1
`define SOFT_WDT_RESET   1'b0

// interrupt status bits
`define EV_POR           0
`define EV_BOR           1
`define EV_STALL_DONE    2
`define EV_WIDTH         3

// stall times, ns; minimum rounded up to cycles
`define CLK_PERIOD_NS    5
`define SLOW_STALL_NS    100000
`define FAST_STALL_NS    1250
`define SLOW_STALL_CYC   ((`SLOW_STALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAST_STALL_CYC   ((`FAST_STALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [verilog/pwr_ctl_pkg.sv]
// Purpose: types of the reset source and power control block
// Assumes: nothing
// Notes:   gray coded stall states
package pwr_ctl_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_STALL = 2'b01
  } stall_state_t;
endpackage

// [verilog/reset_source_power_control.sv]
// Purpose: reset cause flags, rc speed select, soft watchdog enable
// Assumes: axi4-lite slave, 32-bit data, one access of each kind at a time
// Notes:   flags survive aresetn; only power events and software writes touch them
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pwr_ctl_map.svh"
module reset_source_power_control
  import pwr_ctl_pkg::*;
#(
  parameter int unsigned SLOW_STALL = `SLOW_STALL_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        watchdog_config_enable,
  input  wire logic        brownout_detect_enable,
  input  wire logic        rc_mode,
  input  wire logic        por_event,
  input  wire logic        bor_event,
  output logic             watchdog_run,
  output logic             rc_fast_select,
  output logic             core_stall,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // bus handshake

  logic        aw_held_reg;
  logic [9:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic        w_lane_reg;
  logic        ar_held_reg;
  logic [9:0]  ar_addr_reg;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire do_read  = ar_held_reg & ~s_axi_rvalid;

  function automatic logic [1:0] decode(input logic [9:0] a);
    if (a[9:2] == `PRS_INDEX) decode = 2'd1;
    else if (a[9:2] == `IRQ_STATUS_IDX) decode = 2'd2;
    else if (a[9:2] == `IRQ_MASK_IDX) decode = 2'd3;
    else decode = 2'd0;
  endfunction

  wire [1:0] wsel = decode(aw_addr_reg);
  wire [1:0] rsel = decode(ar_addr_reg);
  wire wr_prs  = do_write & (wsel == 2'd1) & w_lane_reg;
  wire wr_stat = do_write & (wsel == 2'd2) & w_lane_reg;
  wire wr_mask = do_write & (wsel == 2'd3) & w_lane_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      ar_held_reg <= 1'b0;
      aw_addr_reg <= 10'h000;
      w_data_reg  <= 32'h0000_0000;
      w_lane_reg  <= 1'b0;
      ar_addr_reg <= 10'h000;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[9:2], 2'b00};
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_lane_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        ar_held_reg <= 1'b1;
        ar_addr_reg <= {s_axi_araddr[9:2], 2'b00};
      end else if (do_read) begin
        ar_held_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power control register

  // flags are kept apart from aresetn: pin and watchdog resets keep them
  logic por_flag_reg;
  logic bor_flag_reg;
  logic speed_reg;
  logic soft_wdt_reg;

  // clear wins over a same-cycle software set
  always_ff @(posedge aclk) begin
    if (por_event) begin
      por_flag_reg <= 1'b0;                               // [R07] [R12]
    end else if (wr_prs) begin
      por_flag_reg <= w_data_reg[`BIT_POR];               // [R11]
    end
  end

  // power-on leaves it as it was: undefined until software sets it
  always_ff @(posedge aclk) begin
    if (bor_event & brownout_detect_enable) begin
      bor_flag_reg <= 1'b0;                               // [R08] [R12]
    end else if (wr_prs) begin
      bor_flag_reg <= w_data_reg[`BIT_BOR];               // [R09] [R10]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_reg    <= `SPEED_RESET;
      soft_wdt_reg <= `SOFT_WDT_RESET;
    end else if (wr_prs) begin
      speed_reg    <= w_data_reg[`BIT_SPEED];
      // locked while the config word forces the watchdog on
      if (!watchdog_config_enable) begin
        soft_wdt_reg <= w_data_reg[`BIT_SOFT_WDT];        // [R02]
      end
    end
  end

  wire soft_wdt_view = soft_wdt_reg | watchdog_config_enable; // [R02]
  wire [7:0] prs_view = {3'b000, soft_wdt_view, speed_reg,
                         1'b0, por_flag_reg, bor_flag_reg}  // [R01]
                        & `PRS_WMASK;

  ////////////////////////////////////////////////////////////////////////
  // speed change stall

  stall_state_t state_reg;
  logic [31:0]  stall_cnt_reg;
  logic         fast_now_reg;
  wire          fast_want = rc_mode & speed_reg;           // [R04]
  wire          change    = fast_want != fast_now_reg;
  wire          stall_end = (state_reg == ST_STALL) && (stall_cnt_reg == 32'd1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ST_RUN;
      stall_cnt_reg <= 32'd0;
      fast_now_reg  <= `SPEED_RESET;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (change && rc_mode) begin
            state_reg     <= ST_STALL;
            stall_cnt_reg <= fast_want ? 32'(`FAST_STALL_CYC) // [R06]
                                       : SLOW_STALL;          // [R05]
          end else if (change) begin
            fast_now_reg <= fast_want;
          end
        end
        ST_STALL: begin
          stall_cnt_reg <= stall_cnt_reg - 32'd1;
          if (stall_cnt_reg == 32'd1) begin
            state_reg    <= ST_RUN;
            fast_now_reg <= fast_want;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins

  logic [`EV_WIDTH-1:0] stat_reg;
  logic [`EV_WIDTH-1:0] mask_reg;
  wire  [`EV_WIDTH-1:0] ev = {stall_end, bor_event & brownout_detect_enable,
                              por_event};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      stat_reg <= ev | (stat_reg &
                  ~(wr_stat ? w_data_reg[`EV_WIDTH-1:0] : '0));
      if (wr_mask) mask_reg <= w_data_reg[`EV_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  wire [31:0] rd_mux = (rsel == 2'd1) ? {24'h000000, prs_view} :
                       (rsel == 2'd2) ? {29'h0, stat_reg} :
                       (rsel == 2'd3) ? {29'h0, mask_reg} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_arready  <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= 2'b00;
      s_axi_rvalid   <= 1'b0;
      s_axi_rresp    <= 2'b00;
      s_axi_rdata    <= 32'h0000_0000;
      watchdog_run   <= 1'b0;
      rc_fast_select <= 1'b1;
      core_stall     <= 1'b0;
      irq            <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~aw_take & ~s_axi_awready;
      s_axi_wready  <= ~w_held_reg & ~w_take & ~s_axi_wready;
      s_axi_arready <= ~ar_held_reg & ~s_axi_arready & ~s_axi_rvalid;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == 2'd0) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= (rsel == 2'd0) ? 2'b10 : 2'b00;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      watchdog_run   <= soft_wdt_view;                    // [R03]
      rc_fast_select <= fast_now_reg;                     // [R04]
      // full count of cycles: minimum stall time is a hard floor
      core_stall     <= (state_reg == ST_STALL);          // [R05] [R06]
      irq            <= |(stat_reg & mask_reg);
    end
  end

endmodule
